// *** core/sktr_cfg.svh ***
// constants for the skip and table-read execution block
`ifndef SKTR_CFG_SVH
`define SKTR_CFG_SVH
`define SKTR_DATA_W      8
`define SKTR_PROG_W      15
`define SKTR_PC_W        12
`define SKTR_TABLE_HIGH_BYTE_REG_W      7
`define SKTR_LAST_PAGE   4'hF
`define SKTR_TABLE_HIGH_BYTE_REG_RESET  8'h00
`define SKTR_ACC_RESET   8'h00
`endif

// *** core/sktr_pkg.sv ***
// types for the skip and table-read execution block
package sktr_pkg;
	typedef enum logic [2:0] {
		SKTR_OP_NONE,
		SKTR_OP_SKIP_ZERO,
		SKTR_OP_SKIP_ZERO_MOVE,
		SKTR_OP_SKIP_BIT,
		SKTR_OP_TAB_CUR,
		SKTR_OP_TAB_LAST
	} sktr_op_t;
	typedef enum logic [1:0] {
		SKTR_IDLE,
		SKTR_DUMMY,
		SKTR_TAB_WAIT
	} sktr_state_t;
endpackage

// *** core/sktr_zero_test.sv ***
// zero test of a byte or of one selected bit of it
`timescale 1ns/1ps
module sktr_zero_test (
	input  wire logic [7:0] value,
	input  wire logic [2:0] bit_sel,
	input  wire logic       bit_mode,
	output logic            is_zero
);
	// bit mode looks only at the chosen bit
	always_comb begin
		if (bit_mode) begin
			is_zero = ~value[bit_sel];
		end else begin
			is_zero = (value == 8'h00);
		end
	end
endmodule

// *** core/sktr_exec.sv ***
// execution of zero skips, skip with move and table reads
// Contract
// RULE1: a zero-skip on a zero data byte suppresses the next instruction and touches no flag.
// RULE2: a taken skip turns the next slot into a dummy no-op cycle, so the skip takes two cycles.
// RULE3: a skip whose tested value is nonzero inserts no dummy cycle.
// RULE4: skip-with-move copies the data byte to the accumulator and skips when it is zero.
// RULE5: the bit-test skip looks only at the selected bit and skips when it is zero.
// RULE6: current-page table read puts the low byte in data memory and the high bits in table-high.
// RULE7: last-page table read does the same from the last program page at the pointer offset.
// RULE8: table-high takes the program bits above the low byte and unused bits read zero.
`timescale 1ns/1ps
`include "sktr_cfg.svh"
module sktr_exec (
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	input  wire logic                     issue,
	input  wire sktr_pkg::sktr_op_t       op,
	input  wire logic [2:0]               bit_sel,
	input  wire logic [`SKTR_DATA_W-1:0]  mem_rdata,
	input  wire logic [`SKTR_PC_W-1:0]    pc,
	input  wire logic [`SKTR_DATA_W-1:0]  table_pointer_reg,
	input  wire logic [`SKTR_PROG_W-1:0]  prog_rdata,
	output logic                          suppress_next,
	output logic                          busy,
	output logic                          prog_rd,
	output logic [`SKTR_PC_W-1:0]         prog_addr,
	output logic                          mem_we,
	output logic [`SKTR_DATA_W-1:0]       mem_wdata,
	output logic [`SKTR_DATA_W-1:0]       accumulator,
	output logic [`SKTR_DATA_W-1:0]       table_high_byte_reg,
	output logic                          flags_we
);
	typedef struct packed {
		sktr_pkg::sktr_state_t       state;
		logic                        suppress_next;
		logic                        busy;
		logic                        prog_rd;
		logic [`SKTR_PC_W-1:0]       prog_addr;
		logic                        mem_we;
		logic [`SKTR_DATA_W-1:0]     mem_wdata;
		logic [`SKTR_DATA_W-1:0]     accumulator;
		logic [`SKTR_DATA_W-1:0]     table_high_byte_reg;
		logic                        flags_we;
	} sktr_regs_t;

	sktr_regs_t r;
	sktr_regs_t next_r;
	logic       rst_meta;
	logic       rst_sync;
	logic       is_zero;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// shared zero detector for all three skip kinds
	sktr_zero_test u_zero (
		.value    (mem_rdata),
		.bit_sel  (bit_sel),
		.bit_mode (op == sktr_pkg::SKTR_OP_SKIP_BIT),
		.is_zero  (is_zero)
	);

	// next state of the whole block
	always_comb begin
		next_r = r;
		next_r.suppress_next = 1'b0;
		next_r.prog_rd = 1'b0;
		next_r.mem_we = 1'b0;
		next_r.busy = 1'b0;
		next_r.flags_we = 1'b0; // RULE1 RULE4 RULE5
		unique case (r.state)
			sktr_pkg::SKTR_IDLE: begin
				if (issue) begin
					unique case (op)
						sktr_pkg::SKTR_OP_SKIP_ZERO,
						sktr_pkg::SKTR_OP_SKIP_BIT: begin
							if (is_zero) begin // RULE1 RULE5
								next_r.suppress_next = 1'b1; // RULE2
								next_r.busy = 1'b1;
								next_r.state = sktr_pkg::SKTR_DUMMY;
							end
						end
						sktr_pkg::SKTR_OP_SKIP_ZERO_MOVE: begin
							next_r.accumulator = mem_rdata; // RULE4
							if (is_zero) begin // RULE4
								next_r.suppress_next = 1'b1; // RULE2
								next_r.busy = 1'b1;
								next_r.state = sktr_pkg::SKTR_DUMMY;
							end
						end
						sktr_pkg::SKTR_OP_TAB_CUR: begin
							// page bits come from the program counter
							next_r.prog_addr = {pc[`SKTR_PC_W-1:`SKTR_DATA_W],
								table_pointer_reg}; // RULE6
							next_r.prog_rd = 1'b1;
							next_r.busy = 1'b1;
							next_r.state = sktr_pkg::SKTR_TAB_WAIT;
						end
						sktr_pkg::SKTR_OP_TAB_LAST: begin
							next_r.prog_addr = {`SKTR_LAST_PAGE, table_pointer_reg}; // RULE7
							next_r.prog_rd = 1'b1;
							next_r.busy = 1'b1;
							next_r.state = sktr_pkg::SKTR_TAB_WAIT;
						end
						default: begin
							next_r.state = sktr_pkg::SKTR_IDLE; // RULE3
						end
					endcase
				end
			end
			sktr_pkg::SKTR_DUMMY: begin
				// the fetched instruction is discarded in this slot
				next_r.state = sktr_pkg::SKTR_IDLE;
			end
			sktr_pkg::SKTR_TAB_WAIT: begin
				// program memory answers in the same cycle as the read strobe
				next_r.mem_wdata = prog_rdata[`SKTR_DATA_W-1:0]; // RULE6
				next_r.mem_we = 1'b1;
				next_r.table_high_byte_reg = {1'b0,
					prog_rdata[`SKTR_PROG_W-1:`SKTR_DATA_W]}; // RULE8
				next_r.state = sktr_pkg::SKTR_IDLE;
			end
			default: begin
				next_r.state = sktr_pkg::SKTR_IDLE;
			end
		endcase
	end

	// single register bank for all state except the two reset synchronizer flops
	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			r <= '{state: sktr_pkg::SKTR_IDLE, suppress_next: 1'b0, busy: 1'b0,
				prog_rd: 1'b0, prog_addr: 12'h000, mem_we: 1'b0, mem_wdata: 8'h00,
				accumulator: `SKTR_ACC_RESET, table_high_byte_reg: `SKTR_TABLE_HIGH_BYTE_REG_RESET,
				flags_we: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign suppress_next = r.suppress_next;
	assign busy = r.busy;
	assign prog_rd = r.prog_rd;
	assign prog_addr = r.prog_addr;
	assign mem_we = r.mem_we;
	assign mem_wdata = r.mem_wdata;
	assign accumulator = r.accumulator;
	assign table_high_byte_reg = r.table_high_byte_reg;
	assign flags_we = r.flags_we; // RULE1 RULE4 RULE5

	sequence zero_skip_issue_s;
		issue && r.state == sktr_pkg::SKTR_IDLE && is_zero &&
			(op == sktr_pkg::SKTR_OP_SKIP_ZERO || op == sktr_pkg::SKTR_OP_SKIP_ZERO_MOVE ||
			op == sktr_pkg::SKTR_OP_SKIP_BIT);
	endsequence
	sequence dummy_slot_s;
		suppress_next ##1 !suppress_next;
	endsequence

	zero_skip_taken_a: assert property (@(posedge clk) disable iff (!rst_sync) // RULE1
		zero_skip_issue_s |=> dummy_slot_s)
		else $error("zero skip did not insert one dummy slot");
	nonzero_no_skip_a: assert property (@(posedge clk) disable iff (!rst_sync) // RULE3
		(issue && r.state == sktr_pkg::SKTR_IDLE && !is_zero) |=> !suppress_next)
		else $error("dummy slot inserted for nonzero value");
	skip_two_cycles_a: assert property (@(posedge clk) disable iff (!rst_sync) // RULE2
		suppress_next |-> busy ##1 (r.state == sktr_pkg::SKTR_IDLE))
		else $error("skip did not end after two cycles");
	move_acc_a: assert property (@(posedge clk) disable iff (!rst_sync) // RULE4
		(issue && r.state == sktr_pkg::SKTR_IDLE && op == sktr_pkg::SKTR_OP_SKIP_ZERO_MOVE)
		|=> accumulator == $past(mem_rdata))
		else $error("accumulator not loaded by skip with move");
	bit_test_a: assert property (@(posedge clk) disable iff (!rst_sync) // RULE5
		(issue && r.state == sktr_pkg::SKTR_IDLE && op == sktr_pkg::SKTR_OP_SKIP_BIT)
		|=> suppress_next == !$past(mem_rdata[bit_sel]))
		else $error("bit test skip wrong");
	tab_cur_addr_a: assert property (@(posedge clk) disable iff (!rst_sync) // RULE6
		(issue && r.state == sktr_pkg::SKTR_IDLE && op == sktr_pkg::SKTR_OP_TAB_CUR)
		|=> prog_rd && prog_addr == {$past(pc[11:8]), $past(table_pointer_reg)}
		##1 mem_we && mem_wdata == $past(prog_rdata[7:0]))
		else $error("current page table read wrong");
	tab_last_addr_a: assert property (@(posedge clk) disable iff (!rst_sync) // RULE7
		(issue && r.state == sktr_pkg::SKTR_IDLE && op == sktr_pkg::SKTR_OP_TAB_LAST)
		|=> prog_rd && prog_addr == {4'hF, $past(table_pointer_reg)})
		else $error("last page table read wrong");
	table_high_byte_reg_high_a: assert property (@(posedge clk) disable iff (!rst_sync) // RULE8
		mem_we |-> table_high_byte_reg == {1'b0, $past(prog_rdata[14:8])})
		else $error("table high register wrong");
	no_flags_a: assert property (@(posedge clk) disable iff (!rst_sync) // RULE1
		!flags_we)
		else $error("skip instruction wrote flags");

	// an issue outside the idle state must leave no trace in the next slot
	idle_refuse_a: assert property (@(posedge clk) disable iff (!rst_sync) // RULE2
		(r.state != sktr_pkg::SKTR_IDLE) |=> !prog_rd && !suppress_next)
		else $error("issue taken while busy");
	nonzero_not_busy_a: assert property (@(posedge clk) disable iff (!rst_sync) // RULE3
		(issue && r.state == sktr_pkg::SKTR_IDLE && !is_zero &&
		op != sktr_pkg::SKTR_OP_TAB_CUR && op != sktr_pkg::SKTR_OP_TAB_LAST) |=> !busy)
		else $error("nonzero skip held the core busy");

	// table read: strobe slot, then write slot, then quiet
	sequence tab_read_s;
		prog_rd && busy ##1 mem_we && !prog_rd && !busy ##1 !mem_we;
	endsequence
	tab_steps_a: assert property (@(posedge clk) disable iff (!rst_sync) // RULE6
		prog_rd |-> tab_read_s)
		else $error("table read steps out of order");
	mem_data_only_table_a: assert property (@(posedge clk) disable iff (!rst_sync) // RULE6
		$changed(mem_wdata) |-> mem_we)
		else $error("data memory byte moved outside a table read");
	acc_only_move_a: assert property (@(posedge clk) disable iff (!rst_sync) // RULE4
		$changed(accumulator) |->
		$past(issue && r.state == sktr_pkg::SKTR_IDLE && op == sktr_pkg::SKTR_OP_SKIP_ZERO_MOVE))
		else $error("accumulator changed without a skip with move");
	table_high_byte_reg_only_table_a: assert property (@(posedge clk) disable iff (!rst_sync) // RULE8
		$changed(table_high_byte_reg) |-> mem_we)
		else $error("table high register changed outside a table read");
endmodule

// *** verif/sktr_prog_model.sv ***
// program memory stand-in that answers table reads
`timescale 1ns/1ps
`include "sktr_cfg.svh"
module sktr_prog_model (
	input  wire logic                    clk,
	input  wire logic                    prog_rd,
	input  wire logic [`SKTR_PC_W-1:0]   prog_addr,
	output logic      [`SKTR_PROG_W-1:0] prog_rdata
);
	logic [`SKTR_PROG_W-1:0] noise = 15'h1A3C;
	// churn outside reads so a stale word never passes for a fresh one
	always_ff @(posedge clk) begin
		noise <= {noise[13:0], ~noise[14]};
	end
	// word is a fixed pattern of its address, served while the strobe stands
	assign prog_rdata = prog_rd ? {prog_addr[11:5], ~prog_addr[7:0]} : noise;
endmodule

// *** verif/sktr_exec_test.sv ***
// self-checking bench for the skip and table-read execution block
`timescale 1ns/1ps
`include "sktr_cfg.svh"
`define SKTR_CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got %0h want %0h", $time, a, e); end end
module sktr_exec_test;
	logic                      clk;
	logic                      reset_n;
	logic                      issue;
	sktr_pkg::sktr_op_t        op;
	logic [2:0]                bit_sel;
	logic [7:0]                mem_rdata;
	logic [`SKTR_PC_W-1:0]     pc;
	logic [7:0]                table_pointer_reg;
	logic [`SKTR_PROG_W-1:0]   prog_rdata;
	logic                      suppress_next;
	logic                      busy;
	logic                      prog_rd;
	logic [`SKTR_PC_W-1:0]     prog_addr;
	logic                      mem_we;
	logic [7:0]                mem_wdata;
	logic [7:0]                accumulator;
	logic [7:0]                table_high_byte_reg;
	logic                      flags_we;
	int                        bad_count;
	int                        checks_done;

	sktr_exec u_sktr_exec (.clk(clk), .reset_n(reset_n), .issue(issue), .op(op),
		.bit_sel(bit_sel), .mem_rdata(mem_rdata), .pc(pc),
		.table_pointer_reg(table_pointer_reg), .prog_rdata(prog_rdata),
		.suppress_next(suppress_next), .busy(busy), .prog_rd(prog_rd),
		.prog_addr(prog_addr), .mem_we(mem_we), .mem_wdata(mem_wdata),
		.accumulator(accumulator), .table_high_byte_reg(table_high_byte_reg),
		.flags_we(flags_we));
	sktr_prog_model u_sktr_prog_model (.clk(clk), .prog_rd(prog_rd),
		.prog_addr(prog_addr), .prog_rdata(prog_rdata));

	// 25 MHz
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic wrap_up;
		if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// one issue cycle; returns just after the edge that takes it
	task automatic run_op(input sktr_pkg::sktr_op_t o, input logic [7:0] d,
		input logic [2:0] b);
		@(posedge clk); #1;
		issue = 1'b1; op = o; mem_rdata = d; bit_sel = b;
		@(posedge clk); #1;
		issue = 1'b0; mem_rdata = ~d; bit_sel = ~b;
	endtask

	task automatic skip_check(input sktr_pkg::sktr_op_t o, input logic [7:0] d,
		input logic [2:0] b, input logic exp);
		run_op(o, d, b);
		`SKTR_CHK(suppress_next, exp)
		`SKTR_CHK(busy, exp)
		`SKTR_CHK(flags_we, 1'b0)
		@(posedge clk); #1;
		`SKTR_CHK(suppress_next, 1'b0)
		`SKTR_CHK(busy, 1'b0)
	endtask

	task automatic sc_skip_zero;
		skip_check(sktr_pkg::SKTR_OP_SKIP_ZERO, 8'h00, 3'h0, 1'b1);
		skip_check(sktr_pkg::SKTR_OP_SKIP_ZERO, 8'h80, 3'h0, 1'b0);
		skip_check(sktr_pkg::SKTR_OP_SKIP_ZERO, 8'h01, 3'h0, 1'b0);
	endtask

	task automatic sc_skip_move;
		skip_check(sktr_pkg::SKTR_OP_SKIP_ZERO_MOVE, 8'h5A, 3'h0, 1'b0);
		`SKTR_CHK(accumulator, 8'h5A)
		skip_check(sktr_pkg::SKTR_OP_SKIP_ZERO_MOVE, 8'h00, 3'h0, 1'b1);
		`SKTR_CHK(accumulator, 8'h00)
	endtask

	// every bit position, alone clear and alone set
	task automatic sc_skip_bit;
		for (int i = 0; i < 8; i++) begin
			skip_check(sktr_pkg::SKTR_OP_SKIP_BIT, ~(8'h01 << i), 3'(i), 1'b1);
			skip_check(sktr_pkg::SKTR_OP_SKIP_BIT, 8'h01 << i, 3'(i), 1'b0);
		end
	endtask

	task automatic table_check(input sktr_pkg::sktr_op_t o, input logic [11:0] pcv,
		input logic [7:0] ptr, input logic [3:0] page);
		logic [11:0] a;
		a = {page, ptr};
		pc = pcv;
		table_pointer_reg = ptr;
		run_op(o, 8'h00, 3'h0);
		table_pointer_reg = ~ptr;
		`SKTR_CHK(prog_rd, 1'b1)
		`SKTR_CHK(prog_addr, a)
		`SKTR_CHK(busy, 1'b1)
		@(posedge clk); #1;
		`SKTR_CHK(mem_we, 1'b1)
		`SKTR_CHK(mem_wdata, (~a[7:0]))
		`SKTR_CHK(table_high_byte_reg, ({1'b0, a[11:5]}))
		@(posedge clk); #1;
		`SKTR_CHK(mem_we, 1'b0)
	endtask

	// an issue held into the dummy slot is dropped; a no-op issue does nothing
	task automatic sc_refuse;
		@(posedge clk); #1;
		issue = 1'b1; op = sktr_pkg::SKTR_OP_SKIP_ZERO; mem_rdata = 8'h00;
		@(posedge clk); #1;
		op = sktr_pkg::SKTR_OP_TAB_LAST;
		`SKTR_CHK(suppress_next, 1'b1)
		@(posedge clk); #1;
		issue = 1'b0;
		`SKTR_CHK(prog_rd, 1'b0)
		`SKTR_CHK(busy, 1'b0)
		skip_check(sktr_pkg::SKTR_OP_NONE, 8'h00, 3'h0, 1'b0);
	endtask

	task automatic sc_tables;
		table_check(sktr_pkg::SKTR_OP_TAB_CUR, 12'h3A7, 8'hC5, 4'h3);
		table_check(sktr_pkg::SKTR_OP_TAB_CUR, 12'hB10, 8'h2E, 4'hB);
		table_check(sktr_pkg::SKTR_OP_TAB_LAST, 12'h3A7, 8'h1E, 4'hF);
	endtask

	// watchdog well past the expected run length
	initial begin
		#(40 * 3000);
		bad_count++;
		wrap_up();
	end

	initial begin
		bad_count = 0; checks_done = 0; reset_n = 1'b0; issue = 1'b0;
		op = sktr_pkg::SKTR_OP_NONE; bit_sel = 3'h0; mem_rdata = 8'h00;
		pc = 12'h000; table_pointer_reg = 8'h00;
		repeat (8) @(posedge clk);
		#1 reset_n = 1'b1;
		// internal reset copy needs two edges before the first issue
		repeat (3) @(posedge clk);
		sc_skip_zero();
		sc_skip_move();
		sc_skip_bit();
		sc_tables();
		sc_refuse();
		wrap_up();
	end
endmodule
